/* hdl/cvd_pkg.sv */
// Constants and types for the CC, supply, power and debug interrupt enables and filter periods.
// Assumes a 50 MHz ref_clk and an 8-bit register port with 12-bit addresses.
package cvd_pkg;

	typedef logic [7:0]  cvd_byte_t;
	typedef logic [11:0] cvd_addr_t;
	typedef logic [15:0] cvd_div_t;

	localparam cvd_addr_t CVD_OFF_CC_IRQ_MASK     = 12'h811;
	localparam cvd_addr_t CVD_OFF_CC1_MATCH_MASK  = 12'h812;
	localparam cvd_addr_t CVD_OFF_CC2_MATCH_MASK  = 12'h813;
	localparam cvd_addr_t CVD_OFF_SUPPLY_MASK     = 12'h814;
	localparam cvd_addr_t CVD_OFF_POWER_MASK      = 12'h815;
	localparam cvd_addr_t CVD_OFF_DEBUG_MASK      = 12'h816;
	localparam cvd_addr_t CVD_OFF_MATCH_PERIOD    = 12'h817;
	localparam cvd_addr_t CVD_OFF_PD_PERIOD       = 12'h818;
	localparam cvd_addr_t CVD_OFF_CABLE_PERIOD    = 12'h819;

	localparam cvd_byte_t CVD_RST_MASK            = 8'h00;
	localparam cvd_byte_t CVD_RST_MATCH_PERIOD    = 8'h02;
	localparam cvd_byte_t CVD_RST_PD_PERIOD       = 8'h0a;
	localparam cvd_byte_t CVD_RST_CABLE_PERIOD    = 8'h02;
	localparam cvd_byte_t CVD_READ_UNMAPPED       = 8'h00;

	// Writable bits of each mixed-access register
	localparam cvd_byte_t CVD_WMASK_CC_IRQ        = 8'hf3;
	localparam cvd_byte_t CVD_WMASK_ALL           = 8'hff;
	localparam cvd_byte_t CVD_WMASK_SUPPLY        = 8'h3d;
	localparam cvd_byte_t CVD_WMASK_DEBUG         = 8'h07;
	localparam cvd_byte_t CVD_WMASK_DEBUG_DFP     = 8'h08;

	// Match period used while running standalone, where the register is not applied
	localparam cvd_byte_t CVD_STANDALONE_PERIOD   = 8'h02;

	localparam int        CVD_CLK_PERIOD_NS       = 20;
	localparam int        CVD_FINE_UNIT_US        = 100;
	localparam int        CVD_MS_UNIT_US          = 1000;
	localparam int        CVD_FINE_UNIT_CYCLES    = CVD_FINE_UNIT_US * 1000 / CVD_CLK_PERIOD_NS;
	localparam int        CVD_MS_UNIT_CYCLES      = CVD_MS_UNIT_US * 1000 / CVD_CLK_PERIOD_NS;

	localparam int        CVD_CC_RAW_W            = 16;
	localparam int        CVD_PD_RAW_W            = 2;
	localparam int        CVD_CABLE_RAW_W         = 3;
	localparam int        CVD_SYNC_W              = CVD_CC_RAW_W + CVD_PD_RAW_W + CVD_CABLE_RAW_W;
	localparam int        CVD_PD_LSB              = CVD_CC_RAW_W;
	localparam int        CVD_CABLE_LSB           = CVD_CC_RAW_W + CVD_PD_RAW_W;

	localparam cvd_div_t  CVD_DIV_ZERO            = 16'h0000;
	localparam cvd_div_t  CVD_DIV_ONE             = 16'h0001;
	localparam cvd_byte_t CVD_COUNT_ONE           = 8'h01;

endpackage

/* hdl/cvd_filter.sv */
// Stability filter: a vector must hold still for a programmed number of unit ticks
// before it is passed on. Assumes raw is already in the ref_clk domain.
`timescale 1ns/1ps

module cvd_filter #(
	parameter int W = 1
) (
	input  wire logic             ref_clk,   // 50 MHz clock
	input  wire logic             rst,       // Synchronous reset
	input  wire logic [W-1:0]     raw,       // Synchronised comparator results
	input  wire logic             unit_tick, // One pulse per time unit
	input  wire cvd_pkg::cvd_byte_t period,  // Stable time in units
	input  wire logic             enable,    // Filter running
	output logic      [W-1:0]     filtered,  // Accepted vector
	output logic                  updated    // Pulse when filtered changes
);
	import cvd_pkg::*;

	typedef struct packed {
		logic [W-1:0] held;
		logic [W-1:0] filt;
		cvd_byte_t    count;
		logic         upd;
	} cvd_flt_state_t;

	cvd_flt_state_t s_q;
	cvd_flt_state_t s_d;

	// Unit ticks are free running, so the first unit may be partial: +/-1 unit
	always_comb begin
		s_d = s_q;
		s_d.upd = 1'b0;
		if (!enable) begin
			s_d.held = raw;
			s_d.count = '0;
		end else if (raw != s_q.held) begin
			s_d.held = raw;
			s_d.count = '0;
		end else if (s_q.filt != s_q.held) begin
			if (s_q.count >= period) begin
				s_d.filt = s_q.held;
				s_d.upd = 1'b1;
				s_d.count = '0;
			end else if (unit_tick) begin
				s_d.count = s_q.count + CVD_COUNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign filtered = s_q.filt;
	assign updated  = s_q.upd;

endmodule

/* hdl/cvd_irq_filter_regs.sv */
// Interrupt enable masks and filter periods for the CC pins, supply, power and debug.
// Assumes status vectors come from same-clock logic; comparator results are asynchronous.
`timescale 1ns/1ps

// Contract
// - The CC mask has writable enables at 7:4 and 1:0, a zero blocks that source, 3:2 reserved.
// - Each CC pin's eight-bit mask lets a change flag raise that pin's interrupt only where set.
// - The supply mask gates supply flags; bits 5:2 and 0 writable, 1 read-only, 7:6 reserved.
// - The power mask has eight enables, a zero blocks that power interrupt.
// - The debug mask has enables 2:0 and bits 7:4 are reserved reading zero.
// - Debug enable bit 3 exists only as a standalone downstream port, otherwise reserved.
// - Outside standalone the match period sets CC comparator stability time, default 2h.
// - The match period counts 100 us units when the unit select is one, coarser when zero.
// - The applied match filter time may be off by one unit either way.
// - The PD period sets the PD filter interval in 1 ms units, default Ah.
// - The cable-power period filters over-current and back-drive in 1 ms units, default 2h.
module cvd_irq_filter_regs #(
	parameter int FINE_UNIT_CYCLES = cvd_pkg::CVD_FINE_UNIT_CYCLES,
	parameter int MS_UNIT_CYCLES   = cvd_pkg::CVD_MS_UNIT_CYCLES
) (
	input  wire logic               ref_clk,           // 50 MHz clock
	input  wire logic               rst,               // Synchronous reset, high
	input  wire cvd_pkg::cvd_addr_t reg_addr,          // Register address
	input  wire logic               reg_wr_en,         // Write strobe
	input  wire logic               reg_rd_en,         // Read strobe
	input  wire cvd_pkg::cvd_byte_t reg_wdata,         // Write data
	output cvd_pkg::cvd_byte_t      reg_rdata,         // Read data
	output logic                    reg_rd_valid,      // Read data valid pulse
	input  wire cvd_pkg::cvd_byte_t cc_irq_sources,    // CC interrupt status
	input  wire cvd_pkg::cvd_byte_t cc1_change_flags,  // Pin 1 change status
	input  wire cvd_pkg::cvd_byte_t cc2_change_flags,  // Pin 2 change status
	input  wire cvd_pkg::cvd_byte_t supply_change_flags, // Supply change status
	input  wire cvd_pkg::cvd_byte_t power_irq_sources, // Power interrupt status
	input  wire logic [3:0]         debug_irq_sources, // Debug interrupt status
	input  wire logic               standalone_mode,   // Standalone operation
	input  wire logic               standalone_dfp,    // Standalone downstream port
	input  wire logic               match_filter_unit_select, // 1: 100 us units
	input  wire logic               cc_filter_enable,  // CC debouncer enable
	input  wire logic               cable_power_overcurrent_detect_enable, // OC filter enable
	input  wire cvd_pkg::cvd_byte_t cc1_cmp_raw,       // Pin 1 comparators, async
	input  wire cvd_pkg::cvd_byte_t cc2_cmp_raw,       // Pin 2 comparators, async
	input  wire logic [1:0]         pd_raw,            // PD detect levels, async
	input  wire logic               cable_oc_raw,      // Cable power over-current, async
	input  wire logic [1:0]         backdrive_raw,     // Back-drive on pin 1/2, async
	output logic                    cc_irq,            // CC interrupt
	output logic                    pin1_match_change_irq, // Pin 1 match change
	output logic                    pin2_match_change_irq, // Pin 2 match change
	output logic                    supply_irq,        // Supply interrupt
	output logic                    power_irq,         // Power interrupt
	output logic                    debug_irq,         // Debug interrupt
	output cvd_pkg::cvd_byte_t      cc1_match,         // Filtered pin 1 comparators
	output cvd_pkg::cvd_byte_t      cc2_match,         // Filtered pin 2 comparators
	output logic                    cc_match_update,   // Pulse on match change
	output logic [1:0]              pd_filtered,       // Filtered PD levels
	output logic                    cable_oc_filtered, // Filtered over-current
	output logic [1:0]              backdrive_filtered, // Filtered back-drive
	output cvd_pkg::cvd_byte_t      match_filter_period, // Programmed match period
	output cvd_pkg::cvd_byte_t      pd_filter_period,  // Programmed PD period
	output cvd_pkg::cvd_byte_t      cable_power_fault_filter_period // Programmed cable period
);
	import cvd_pkg::*;

	localparam cvd_div_t FINE_LAST = cvd_div_t'(FINE_UNIT_CYCLES - 1);
	localparam cvd_div_t MS_LAST   = cvd_div_t'(MS_UNIT_CYCLES - 1);

	typedef struct packed {
		cvd_byte_t             cc_mask;
		cvd_byte_t             cc1_mask;
		cvd_byte_t             cc2_mask;
		cvd_byte_t             supply_mask;
		cvd_byte_t             power_mask;
		cvd_byte_t             debug_mask;
		cvd_byte_t             match_period;
		cvd_byte_t             pd_period;
		cvd_byte_t             cable_period;
		cvd_byte_t             rdata;
		logic                  rvalid;
		logic [CVD_SYNC_W-1:0] sync1;
		logic [CVD_SYNC_W-1:0] sync2;
		cvd_div_t              fine_cnt;
		cvd_div_t              ms_cnt;
		logic                  fine_tick;
		logic                  ms_tick;
		logic [5:0]            irq;
	} cvd_state_t;

	cvd_state_t s_q;
	cvd_state_t s_d;

	logic       match_tick;
	cvd_byte_t  match_period_eff;
	cvd_byte_t  debug_mask_eff;
	cvd_byte_t  debug_wmask;

	function automatic cvd_byte_t masked_write(cvd_byte_t old, cvd_byte_t wr, cvd_byte_t wm);
		masked_write = (old & ~wm) | (wr & wm);
	endfunction

	function automatic cvd_div_t next_div(cvd_div_t cnt, cvd_div_t last);
		next_div = (cnt >= last) ? CVD_DIV_ZERO : cnt + CVD_DIV_ONE;
	endfunction

	// Bit 3 of the debug mask only exists as a standalone downstream port
	assign debug_wmask = standalone_dfp ? (CVD_WMASK_DEBUG | CVD_WMASK_DEBUG_DFP)
	                                    : CVD_WMASK_DEBUG;
	assign debug_mask_eff = s_q.debug_mask & debug_wmask;

	// Coarse unit is taken as 1 ms; software must size the period for the thresholds
	assign match_tick = match_filter_unit_select ? s_q.fine_tick : s_q.ms_tick;
	assign match_period_eff = standalone_mode ? CVD_STANDALONE_PERIOD
	                                          : s_q.match_period;

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;

		s_d.sync1 = {backdrive_raw, cable_oc_raw, pd_raw, cc2_cmp_raw, cc1_cmp_raw};
		s_d.sync2 = s_q.sync1;

		s_d.fine_cnt  = next_div(s_q.fine_cnt, FINE_LAST);
		s_d.fine_tick = (s_q.fine_cnt >= FINE_LAST);
		s_d.ms_cnt    = next_div(s_q.ms_cnt, MS_LAST);
		s_d.ms_tick   = (s_q.ms_cnt >= MS_LAST);

		if (reg_wr_en) begin
			case (reg_addr)
				CVD_OFF_CC_IRQ_MASK: begin
					s_d.cc_mask = masked_write(s_q.cc_mask, reg_wdata, CVD_WMASK_CC_IRQ);
				end
				CVD_OFF_CC1_MATCH_MASK: begin
					s_d.cc1_mask = reg_wdata;
				end
				CVD_OFF_CC2_MATCH_MASK: begin
					s_d.cc2_mask = reg_wdata;
				end
				CVD_OFF_SUPPLY_MASK: begin
					s_d.supply_mask = masked_write(s_q.supply_mask, reg_wdata,
					                               CVD_WMASK_SUPPLY);
				end
				CVD_OFF_POWER_MASK: begin
					s_d.power_mask = masked_write(s_q.power_mask, reg_wdata,
					                              CVD_WMASK_ALL);
				end
				CVD_OFF_DEBUG_MASK: begin
					s_d.debug_mask = masked_write(s_q.debug_mask, reg_wdata,
					                              debug_wmask);
				end
				CVD_OFF_MATCH_PERIOD: begin
					s_d.match_period = reg_wdata;
				end
				CVD_OFF_PD_PERIOD: begin
					s_d.pd_period = reg_wdata;
				end
				CVD_OFF_CABLE_PERIOD: begin
					s_d.cable_period = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		if (reg_rd_en) begin
			s_d.rvalid = 1'b1;
			case (reg_addr)
				CVD_OFF_CC_IRQ_MASK:    s_d.rdata = s_q.cc_mask & CVD_WMASK_CC_IRQ;
				CVD_OFF_CC1_MATCH_MASK: s_d.rdata = s_q.cc1_mask;
				CVD_OFF_CC2_MATCH_MASK: s_d.rdata = s_q.cc2_mask;
				CVD_OFF_SUPPLY_MASK:    s_d.rdata = s_q.supply_mask & CVD_WMASK_SUPPLY;
				CVD_OFF_POWER_MASK:     s_d.rdata = s_q.power_mask;
				CVD_OFF_DEBUG_MASK:     s_d.rdata = debug_mask_eff;
				CVD_OFF_MATCH_PERIOD:   s_d.rdata = s_q.match_period;
				CVD_OFF_PD_PERIOD:      s_d.rdata = s_q.pd_period;
				CVD_OFF_CABLE_PERIOD:   s_d.rdata = s_q.cable_period;
				default:                s_d.rdata = CVD_READ_UNMAPPED;
			endcase
		end

		// Level outputs follow status every cycle, so clearing status drops them
		s_d.irq[0] = |(cc_irq_sources & s_q.cc_mask & CVD_WMASK_CC_IRQ);
		s_d.irq[1] = |(cc1_change_flags & s_q.cc1_mask);
		s_d.irq[2] = |(cc2_change_flags & s_q.cc2_mask);
		s_d.irq[3] = |(supply_change_flags & s_q.supply_mask & CVD_WMASK_SUPPLY);
		s_d.irq[4] = |(power_irq_sources & s_q.power_mask);
		s_d.irq[5] = |(debug_irq_sources & debug_mask_eff[3:0]);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.cc_mask      <= CVD_RST_MASK;
			s_q.cc1_mask     <= CVD_RST_MASK;
			s_q.cc2_mask     <= CVD_RST_MASK;
			s_q.supply_mask  <= CVD_RST_MASK;
			s_q.power_mask   <= CVD_RST_MASK;
			s_q.debug_mask   <= CVD_RST_MASK;
			s_q.match_period <= CVD_RST_MATCH_PERIOD;
			s_q.pd_period    <= CVD_RST_PD_PERIOD;
			s_q.cable_period <= CVD_RST_CABLE_PERIOD;
		end else begin
			s_q <= s_d;
		end
	end

	// Periods are read live: a write while a filter runs shifts its current window
	cvd_filter #(
		.W         (CVD_CC_RAW_W)
	) u_match_filter (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.raw       (s_q.sync2[CVD_CC_RAW_W-1:0]),
		.unit_tick (match_tick),
		.period    (match_period_eff),
		.enable    (cc_filter_enable),
		.filtered  ({cc2_match, cc1_match}),
		.updated   (cc_match_update)
	);

	cvd_filter #(
		.W         (CVD_PD_RAW_W)
	) u_pd_filter (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.raw       (s_q.sync2[CVD_PD_LSB +: CVD_PD_RAW_W]),
		.unit_tick (s_q.ms_tick),
		.period    (s_q.pd_period),
		.enable    (cc_filter_enable),
		.filtered  (pd_filtered),
		.updated   ()
	);

	cvd_filter #(
		.W         (CVD_CABLE_RAW_W)
	) u_cable_filter (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.raw       (s_q.sync2[CVD_CABLE_LSB +: CVD_CABLE_RAW_W]),
		.unit_tick (s_q.ms_tick),
		.period    (s_q.cable_period),
		.enable    (cable_power_overcurrent_detect_enable),
		.filtered  ({backdrive_filtered, cable_oc_filtered}),
		.updated   ()
	);

	assign reg_rdata             = s_q.rdata;
	assign reg_rd_valid          = s_q.rvalid;
	assign cc_irq                = s_q.irq[0];
	assign pin1_match_change_irq = s_q.irq[1];
	assign pin2_match_change_irq = s_q.irq[2];
	assign supply_irq            = s_q.irq[3];
	assign power_irq             = s_q.irq[4];
	assign debug_irq             = s_q.irq[5];
	assign match_filter_period   = s_q.match_period;
	assign pd_filter_period      = s_q.pd_period;
	assign cable_power_fault_filter_period = s_q.cable_period;

endmodule

/* verif/cvd_irq_filter_regs_assertions.sv */
// Port-level checker for the interrupt masks and filter period registers.
// Assumes it is bound to cvd_irq_filter_regs and sees only its ports.
`timescale 1ns/1ps

module cvd_irq_filter_regs_assertions (
	input wire logic               ref_clk,             // Clock
	input wire logic               rst,                 // Sync reset
	input wire cvd_pkg::cvd_addr_t reg_addr,            // Address
	input wire logic               reg_wr_en,           // Write strobe
	input wire logic               reg_rd_en,           // Read strobe
	input wire cvd_pkg::cvd_byte_t reg_wdata,           // Write data
	input wire cvd_pkg::cvd_byte_t reg_rdata,           // Read data
	input wire logic               reg_rd_valid,        // Read valid
	input wire cvd_pkg::cvd_byte_t cc_irq_sources,      // CC status
	input wire cvd_pkg::cvd_byte_t cc1_change_flags,    // Pin 1 status
	input wire cvd_pkg::cvd_byte_t supply_change_flags, // Supply status
	input wire cvd_pkg::cvd_byte_t power_irq_sources,   // Power status
	input wire logic [3:0]         debug_irq_sources,   // Debug status
	input wire logic               standalone_dfp,      // Standalone downstream
	input wire logic               cc_filter_enable,    // CC filter enable
	input wire logic               cc_irq,              // CC interrupt
	input wire logic               pin1_match_change_irq, // Pin 1 interrupt
	input wire logic               supply_irq,          // Supply interrupt
	input wire logic               power_irq,           // Power interrupt
	input wire logic               debug_irq,           // Debug interrupt
	input wire cvd_pkg::cvd_byte_t cc1_match,           // Filtered pin 1
	input wire logic               cc_match_update,     // Match update pulse
	input wire cvd_pkg::cvd_byte_t match_filter_period, // Match period
	input wire cvd_pkg::cvd_byte_t pd_filter_period,    // PD period
	input wire cvd_pkg::cvd_byte_t cable_power_fault_filter_period // Cable period
);
	import cvd_pkg::*;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_cc_rsvd;
		reg_rd_en && reg_addr == CVD_OFF_CC_IRQ_MASK |=> reg_rdata[3:2] == 2'h0;
	endproperty
	a_cc_rsvd: assert property (p_cc_rsvd) else $error("cc mask reserved bits read set");
	property p_sup_rsvd;
		reg_rd_en && reg_addr == CVD_OFF_SUPPLY_MASK |=> (reg_rdata & 8'hc2) == 8'h00;
	endproperty
	a_sup_rsvd: assert property (p_sup_rsvd) else $error("supply mask fixed bits read set");
	property p_dbg_rsvd;
		reg_rd_en && reg_addr == CVD_OFF_DEBUG_MASK |=> reg_rd_valid && reg_rdata[7:4] == 4'h0
			&& (!reg_rdata[3] || $past(standalone_dfp));
	endproperty
	a_dbg_rsvd: assert property (p_dbg_rsvd) else $error("debug mask reserved bits read set");
	property p_cc_off; (cc_irq_sources & CVD_WMASK_CC_IRQ) == 8'h00 |=> !cc_irq; endproperty
	a_cc_off: assert property (p_cc_off) else $error("cc irq without usable source");
	property p_pin1_off; cc1_change_flags == 8'h00 |=> !pin1_match_change_irq; endproperty
	a_pin1_off: assert property (p_pin1_off) else $error("pin 1 irq without flag");
	property p_sup_off; (supply_change_flags & CVD_WMASK_SUPPLY) == 8'h00 |=> !supply_irq; endproperty
	a_sup_off: assert property (p_sup_off) else $error("supply irq without usable flag");
	property p_pwr_off; power_irq_sources == 8'h00 |=> !power_irq; endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power irq without source");
	property p_dbg_off;
		(debug_irq_sources & {standalone_dfp, 3'h7}) == 4'h0 |=> !debug_irq;
	endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("debug irq without usable source");
	property p_rst_period;
		$fell(rst) |-> match_filter_period == CVD_RST_MATCH_PERIOD
			&& pd_filter_period == CVD_RST_PD_PERIOD
			&& cable_power_fault_filter_period == CVD_RST_CABLE_PERIOD;
	endproperty
	a_rst_period: assert property (p_rst_period) else $error("period reset value wrong");
	property p_match_wr;
		reg_wr_en && reg_addr == CVD_OFF_MATCH_PERIOD |=> match_filter_period == $past(reg_wdata);
	endproperty
	a_match_wr: assert property (p_match_wr) else $error("match period not written");
	property p_pd_wr;
		reg_wr_en && reg_addr == CVD_OFF_PD_PERIOD |=> pd_filter_period == $past(reg_wdata);
	endproperty
	a_pd_wr: assert property (p_pd_wr) else $error("pd period not written");
	property p_freeze; !cc_filter_enable [*3] |=> $stable(cc1_match); endproperty
	a_freeze: assert property (p_freeze) else $error("match moved while filter off");

	c_update: cover property (cc_match_update);
	c_power: cover property (power_irq);
	c_dbg_dfp: cover property (reg_rd_en && reg_addr == CVD_OFF_DEBUG_MASK && standalone_dfp);
endmodule

/* verif/tb.sv */
// Self-checking bench for cvd_irq_filter_regs: registers, interrupt gating, filter timing.
// Assumes shortened unit counts; all inputs change on the falling edge.
`timescale 1ns/1ps

module tb;
	import cvd_pkg::*;
	localparam int FU = 5;
	localparam int MU = 20;
	logic       ref_clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid, cc_match_update;
	cvd_addr_t  reg_addr;
	cvd_byte_t  reg_wdata, reg_rdata, cc_irq_sources, cc1_change_flags, cc2_change_flags;
	cvd_byte_t  supply_change_flags, power_irq_sources, cc1_cmp_raw, cc2_cmp_raw;
	cvd_byte_t  cc1_match, cc2_match, match_filter_period, pd_filter_period;
	cvd_byte_t  cable_power_fault_filter_period;
	logic [3:0] debug_irq_sources;
	logic [1:0] pd_raw, backdrive_raw, pd_filtered, backdrive_filtered;
	logic       standalone_mode, standalone_dfp, match_filter_unit_select, cc_filter_enable;
	logic       cable_power_overcurrent_detect_enable, cable_oc_raw, cable_oc_filtered;
	logic       cc_irq, pin1_match_change_irq, pin2_match_change_irq, supply_irq, power_irq;
	logic       debug_irq;
	logic [5:0] irqs;
	int         error_cnt, check_count;

	assign irqs = {debug_irq, power_irq, supply_irq,
	               pin2_match_change_irq, pin1_match_change_irq, cc_irq};

	cvd_irq_filter_regs #(.FINE_UNIT_CYCLES(FU), .MS_UNIT_CYCLES(MU)) DUT (.*);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk_byte(input cvd_byte_t got, input cvd_byte_t exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_byte({7'h0, got}, {7'h0, exp}, what);
	endtask

	// Each bus task starts and ends on a falling edge, with a spare cycle so strobes never rebound
	task automatic wr(input cvd_addr_t a, input cvd_byte_t d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge ref_clk);
		reg_wr_en = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic rd(input cvd_addr_t a, input cvd_byte_t exp);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge ref_clk);
		reg_rd_en = 1'b0;
		chk_bit(reg_rd_valid, 1'b1, "read valid");
		chk_byte(reg_rdata, exp, "read data");
		@(negedge ref_clk);
	endtask

	task automatic test_regs();
		cvd_byte_t rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0a, 8'h02};
		cvd_byte_t wv [9] = '{8'hf3, 8'hff, 8'hff, 8'h3d, 8'hff, 8'h07, 8'hff, 8'hff, 8'hff};
		for (int i = 0; i < 9; i++) begin
			rd(CVD_OFF_CC_IRQ_MASK + 12'(i), rv[i]);
			wr(CVD_OFF_CC_IRQ_MASK + 12'(i), 8'hff);
			rd(CVD_OFF_CC_IRQ_MASK + 12'(i), wv[i]);
		end
		wr(12'h81a, 8'h55);
		rd(12'h81a, CVD_READ_UNMAPPED);
		rd(12'h810, CVD_READ_UNMAPPED);
		standalone_dfp = 1'b1;
		wr(CVD_OFF_DEBUG_MASK, 8'hff);
		rd(CVD_OFF_DEBUG_MASK, 8'h0f);
		standalone_dfp = 1'b0;
		rd(CVD_OFF_DEBUG_MASK, 8'h07);
		$display("test_regs done");
	endtask

	task automatic set_src(input int i, input cvd_byte_t v);
		case (i)
			0: cc_irq_sources = v;
			1: cc1_change_flags = v;
			2: cc2_change_flags = v;
			3: supply_change_flags = v;
			4: power_irq_sources = v;
			default: debug_irq_sources = v[3:0];
		endcase
	endtask

	// Enabled source per mask, then a reserved-bit source (CC, supply, debug) or a cleared source (pin 1, pin 2, power)
	task automatic test_irq();
		cvd_byte_t en [6] = '{8'h10, 8'h01, 8'h40, 8'h20, 8'h80, 8'h04};
		cvd_byte_t rs [6] = '{8'h0c, 8'h00, 8'h00, 8'hc2, 8'h00, 8'h08};
		for (int i = 0; i < 6; i++) begin
			wr(CVD_OFF_CC_IRQ_MASK + 12'(i), 8'h00);
			set_src(i, en[i]);
			repeat (2) @(negedge ref_clk);
			chk_bit(irqs[i], 1'b0, "masked source");
			wr(CVD_OFF_CC_IRQ_MASK + 12'(i), 8'hff);
			@(negedge ref_clk);
			chk_bit(irqs[i], 1'b1, "enabled source");
			set_src(i, rs[i]);
			repeat (2) @(negedge ref_clk);
			chk_bit(irqs[i], 1'b0, "reserved or cleared source");
			set_src(i, 8'h00);
		end
		standalone_dfp = 1'b1;
		wr(CVD_OFF_DEBUG_MASK, 8'h08);
		set_src(5, 8'h08);
		repeat (2) @(negedge ref_clk);
		chk_bit(debug_irq, 1'b1, "debug bit 3");
		set_src(5, 8'h00);
		standalone_dfp = 1'b0;
		$display("test_irq done");
	endtask

	task automatic time_filter(input int sel, input cvd_byte_t exp, input int lo, input int hi);
		int        n = 0;
		cvd_byte_t got = 8'h00;
		while (got !== exp && n < 2000) begin
			@(negedge ref_clk);
			n++;
			case (sel)
				0: got = cc1_match;
				1: got = {6'h0, pd_filtered};
				default: got = {5'h0, backdrive_filtered, cable_oc_filtered};
			endcase
		end
		chk_bit(n >= lo && n <= hi, 1'b1, "filter time");
		// The update pulse stands in the same cycle as the new match vector
		if (sel == 0)
			chk_bit(cc_match_update, 1'b1, "match update pulse");
	endtask

	// Each period is only written with its own filter stopped
	task automatic test_filters();
		match_filter_unit_select = 1'b1;
		wr(CVD_OFF_MATCH_PERIOD, 8'h03);
		cc_filter_enable = 1'b1;
		cc1_cmp_raw = 8'h5a;
		cc2_cmp_raw = 8'hc3;
		time_filter(0, 8'h5a, 2 * FU, 4 * FU + 6);
		chk_byte(cc2_match, 8'hc3, "pin 2 match");
		cc_filter_enable = 1'b0;
		match_filter_unit_select = 1'b0;
		wr(CVD_OFF_MATCH_PERIOD, 8'h02);
		cc_filter_enable = 1'b1;
		cc1_cmp_raw = 8'ha5;
		time_filter(0, 8'ha5, MU, 3 * MU + 6);
		cc_filter_enable = 1'b0;
		match_filter_unit_select = 1'b1;
		wr(CVD_OFF_MATCH_PERIOD, 8'h08);
		standalone_mode = 1'b1;
		cc_filter_enable = 1'b1;
		cc1_cmp_raw = 8'h3c;
		time_filter(0, 8'h3c, FU, 3 * FU + 6);
		cc_filter_enable = 1'b0;
		standalone_mode = 1'b0;
		cc1_cmp_raw = 8'h00;
		repeat (60) @(negedge ref_clk);
		chk_byte(cc1_match, 8'h3c, "frozen match");
		wr(CVD_OFF_PD_PERIOD, 8'h04);
		cc_filter_enable = 1'b1;
		pd_raw = 2'h3;
		time_filter(1, 8'h03, 3 * MU, 5 * MU + 6);
		wr(CVD_OFF_CABLE_PERIOD, 8'h02);
		chk_byte(cable_power_fault_filter_period, 8'h02, "cable period port");
		cable_power_overcurrent_detect_enable = 1'b1;
		cable_oc_raw = 1'b1;
		backdrive_raw = 2'h2;
		time_filter(2, 8'h05, MU, 3 * MU + 6);
		$display("test_filters done");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		error_cnt = 0;
		check_count = 0;
		rst = 1'b1;
		{reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
		{cc_irq_sources, cc1_change_flags, cc2_change_flags, supply_change_flags} = '0;
		{power_irq_sources, debug_irq_sources, cc1_cmp_raw, cc2_cmp_raw} = '0;
		{standalone_mode, standalone_dfp, match_filter_unit_select, cc_filter_enable} = '0;
		{cable_power_overcurrent_detect_enable, pd_raw, cable_oc_raw, backdrive_raw} = '0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		test_regs();
		test_irq();
		test_filters();
		give_verdict();
	end

	// Whole run is a few hundred cycles; this bound only catches a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		give_verdict();
	end
endmodule

bind cvd_irq_filter_regs cvd_irq_filter_regs_assertions u_chk (.*);
